// ===== hdl/sjsr_defs.svh
// Constants of the SRAM scan register set: widths, instruction codes, capture values.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef SJSR_DEFS_SVH
`define SJSR_DEFS_SVH

`define SJSR_IR_W          3
`define SJSR_ID_W          32
`define SJSR_BSR_W         107
`define SJSR_BSR_INT_IDX   47

`define SJSR_IR_EXTEST     3'h0
`define SJSR_IR_IDCODE     3'h1
`define SJSR_IR_SAMPLEZ    3'h2
`define SJSR_IR_SAMPLE     3'h4
`define SJSR_IR_BYPASS     3'h7
`define SJSR_IR_CAPTURE    3'h1

`define SJSR_ID_REV_MSB    31
`define SJSR_ID_REV_LSB    28
`define SJSR_ID_PART_MSB   27
`define SJSR_ID_PART_LSB   12
`define SJSR_ID_VEND_MSB   11
`define SJSR_ID_VEND_LSB   1
`define SJSR_ID_FIX_BIT    0

`define SJSR_TMS_RESET_RISES 3'h5
`define SJSR_SYNC_SETTLE     3'h5

`endif

// ===== hdl/sjsr_pkg.sv
// Types shared by the scan register set: controller states and data path choice.
// Assumes nothing beyond a SystemVerilog compiler.
package sjsr_pkg;

  typedef enum logic [3:0] {
    SJSR_TLR, SJSR_RTI, SJSR_SEL_DR, SJSR_CAP_DR, SJSR_SHF_DR, SJSR_EX1_DR,
    SJSR_PAU_DR, SJSR_EX2_DR, SJSR_UPD_DR, SJSR_SEL_IR, SJSR_CAP_IR, SJSR_SHF_IR,
    SJSR_EX1_IR, SJSR_PAU_IR, SJSR_EX2_IR, SJSR_UPD_IR
  } sjsr_tap_e;

  typedef enum logic [1:0] {
    SJSR_PATH_BSR, SJSR_PATH_ID, SJSR_PATH_BYP
  } sjsr_path_e;

endpackage

// ===== hdl/sjsr_pin_sync.sv
// Three-flop synchroniser with agreement filter for inputs from outside mclk_i.
// Assumes each bit stays stable for several mclk_i periods around its changes.
`timescale 1ns/1ps
module sjsr_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] lvl_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A bit moves only once the second and third stages agree
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      lvl_o <= '0;
    end else begin
      lvl_o <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & lvl_o);
    end
  end

endmodule // sjsr_pin_sync

// ===== hdl/sjsr_tap_fsm.sv
// Test access port controller: sixteen states stepped once per test clock rise.
// Assumes step_i is a one-cycle pulse and tms_i is valid in that cycle.
`timescale 1ns/1ps
module sjsr_tap_fsm (
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic              step_i,
  input  wire logic              tms_i,
  output sjsr_pkg::sjsr_tap_e    state_o
);
  import sjsr_pkg::*;

  sjsr_tap_e state_next;

  always_comb begin
    state_next = state_o;
    unique case (state_o)
      SJSR_TLR:    state_next = tms_i ? SJSR_TLR    : SJSR_RTI;
      SJSR_RTI:    state_next = tms_i ? SJSR_SEL_DR : SJSR_RTI;
      SJSR_SEL_DR: state_next = tms_i ? SJSR_SEL_IR : SJSR_CAP_DR;
      SJSR_CAP_DR: state_next = tms_i ? SJSR_EX1_DR : SJSR_SHF_DR;
      SJSR_SHF_DR: state_next = tms_i ? SJSR_EX1_DR : SJSR_SHF_DR;
      SJSR_EX1_DR: state_next = tms_i ? SJSR_UPD_DR : SJSR_PAU_DR;
      SJSR_PAU_DR: state_next = tms_i ? SJSR_EX2_DR : SJSR_PAU_DR;
      SJSR_EX2_DR: state_next = tms_i ? SJSR_UPD_DR : SJSR_SHF_DR;
      SJSR_UPD_DR: state_next = tms_i ? SJSR_SEL_DR : SJSR_RTI;
      SJSR_SEL_IR: state_next = tms_i ? SJSR_TLR    : SJSR_CAP_IR;
      SJSR_CAP_IR: state_next = tms_i ? SJSR_EX1_IR : SJSR_SHF_IR;
      SJSR_SHF_IR: state_next = tms_i ? SJSR_EX1_IR : SJSR_SHF_IR;
      SJSR_EX1_IR: state_next = tms_i ? SJSR_UPD_IR : SJSR_PAU_IR;
      SJSR_PAU_IR: state_next = tms_i ? SJSR_EX2_IR : SJSR_PAU_IR;
      SJSR_EX2_IR: state_next = tms_i ? SJSR_UPD_IR : SJSR_SHF_IR;
      SJSR_UPD_IR: state_next = tms_i ? SJSR_SEL_DR : SJSR_RTI;
    endcase
  end

  // Power-up reset lands in test-logic-reset
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_o <= SJSR_TLR;
    end else if (step_i) begin
      state_o <= state_next;
    end
  end

endmodule // sjsr_tap_fsm

// ===== hdl/sjsr_scan_regs.sv
// Scan register set behind the test access port: instruction, bypass, ID, boundary.
// Assumes the test clock is far slower than mclk_i and has no reset pin of its own.
`timescale 1ns/1ps
`include "sjsr_defs.svh"
module sjsr_scan_regs #(
  // Identification fields; the values are arbitrary
  parameter logic [3:0]  ID_REVISION = 4'h1,
  parameter logic [15:0] ID_PART     = 16'hA5C3,
  parameter logic [10:0] ID_VENDOR   = 11'h2B4
) (
  input  wire logic                     mclk_i,
  input  wire logic                     reset_i,
  input  wire logic                     tck_i,
  input  wire logic                     tms_i,
  input  wire logic                     tdi_i,
  input  wire logic [`SJSR_BSR_W-1:0]   io_ring_i,
  output logic                          tdo_o,
  output logic                          tdo_oe_o,
  output logic      [`SJSR_BSR_W-1:0]   ring_drive_o,
  output logic                          ring_drive_en_o,
  output logic                          q_highz_o
);
  import sjsr_pkg::*;

  localparam logic [`SJSR_ID_W-1:0] ID_CODE = {ID_REVISION, ID_PART, ID_VENDOR, 1'b1};

  logic                    tck_lvl;
  logic                    tms_lvl;
  logic                    tdi_lvl;
  logic [`SJSR_BSR_W-1:0]  ring_lvl;
  logic                    tck_prev_reg;
  logic                    tck_rise;
  logic                    tck_fall;
  logic [2:0]              sync_cnt_reg;
  logic                    sync_done;
  sjsr_tap_e               state;
  logic [`SJSR_IR_W-1:0]   instr_reg;
  logic [`SJSR_IR_W-1:0]   ir_sr_reg;
  logic                    byp_reg;
  logic [`SJSR_ID_W-1:0]   id_sr_reg;
  logic [`SJSR_BSR_W-1:0]  bsr_sr_reg;
  logic [`SJSR_BSR_W-1:0]  ring_cap;
  sjsr_path_e              path;
  logic                    dr_bit;
  logic [2:0]              tms_hi_cnt_reg;

  // Path choice from the current instruction; reserved codes fall back to bypass
  function automatic sjsr_path_e path_of(input logic [`SJSR_IR_W-1:0] ir);
    unique case (ir)
      `SJSR_IR_EXTEST,
      `SJSR_IR_SAMPLEZ,
      `SJSR_IR_SAMPLE: path_of = SJSR_PATH_BSR;
      `SJSR_IR_IDCODE: path_of = SJSR_PATH_ID;
      default:         path_of = SJSR_PATH_BYP;
    endcase
  endfunction

  sjsr_pin_sync #(.W(3)) u_jtag_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .pin_i   ({tck_i, tms_i, tdi_i}),
    .lvl_o   ({tck_lvl, tms_lvl, tdi_lvl})
  );

  // The ring runs on memory clocks; sampling it unstable gives no repeatable value
  sjsr_pin_sync #(.W(`SJSR_BSR_W)) u_ring_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .pin_i   (io_ring_i),
    .lvl_o   (ring_lvl)
  );

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tck_prev_reg <= 1'b0;
    end else begin
      tck_prev_reg <= tck_lvl;
    end
  end

  // Edges stay blind until the synchroniser holds real pin levels, since its
  // reset value need not match the idle level of the test clock
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_cnt_reg <= 3'h0;
    end else if (sync_cnt_reg != `SJSR_SYNC_SETTLE) begin
      sync_cnt_reg <= sync_cnt_reg + 3'h1;
    end
  end

  assign sync_done = (sync_cnt_reg == `SJSR_SYNC_SETTLE);
  assign tck_rise  = tck_lvl & ~tck_prev_reg & sync_done;
  assign tck_fall  = ~tck_lvl & tck_prev_reg & sync_done;

  sjsr_tap_fsm u_tap (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .step_i  (tck_rise),
    .tms_i   (tms_lvl),
    .state_o (state)
  );

  assign path = path_of(instr_reg);

  // Cell 47 has no bump and captures zero
  always_comb begin
    ring_cap = ring_lvl;
    ring_cap[`SJSR_BSR_INT_IDX] = 1'b0;
  end

  always_comb begin
    unique case (path)
      SJSR_PATH_BSR: dr_bit = bsr_sr_reg[0];
      SJSR_PATH_ID:  dr_bit = id_sr_reg[0];
      default:       dr_bit = byp_reg;
    endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ir_sr_reg <= `SJSR_IR_IDCODE;
    end else if (tck_rise) begin
      if (state == SJSR_CAP_IR) begin
        ir_sr_reg <= `SJSR_IR_CAPTURE;
      end else if (state == SJSR_SHF_IR) begin
        ir_sr_reg <= {tdi_lvl, ir_sr_reg[`SJSR_IR_W-1:1]};
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      instr_reg <= `SJSR_IR_IDCODE;
    end else if (state == SJSR_TLR) begin
      instr_reg <= `SJSR_IR_IDCODE;
    end else if (tck_rise && state == SJSR_UPD_IR) begin
      instr_reg <= ir_sr_reg;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      byp_reg <= 1'b0;
    end else if (tck_rise && path == SJSR_PATH_BYP) begin
      if (state == SJSR_CAP_DR) begin
        byp_reg <= 1'b0;
      end else if (state == SJSR_SHF_DR) begin
        byp_reg <= tdi_lvl;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      id_sr_reg <= '0;
    end else if (tck_rise && path == SJSR_PATH_ID) begin
      if (state == SJSR_CAP_DR) begin
        id_sr_reg <= ID_CODE;
      end else if (state == SJSR_SHF_DR) begin
        id_sr_reg <= {tdi_lvl, id_sr_reg[`SJSR_ID_W-1:1]};
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      bsr_sr_reg <= '0;
    end else if (tck_rise && path == SJSR_PATH_BSR) begin
      if (state == SJSR_CAP_DR) begin
        bsr_sr_reg <= ring_cap;
      end else if (state == SJSR_SHF_DR) begin
        bsr_sr_reg <= {tdi_lvl, bsr_sr_reg[`SJSR_BSR_W-1:1]};
      end
    end
  end

  // Update stage so the ring drive does not ripple while shifting
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ring_drive_o <= '0;
    end else if (tck_rise && state == SJSR_UPD_DR && path == SJSR_PATH_BSR) begin
      ring_drive_o <= bsr_sr_reg;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ring_drive_en_o <= 1'b0;
      q_highz_o       <= 1'b0;
    end else begin
      ring_drive_en_o <= (instr_reg == `SJSR_IR_EXTEST);
      q_highz_o       <= (instr_reg == `SJSR_IR_SAMPLEZ);
    end
  end

  // Data out moves on the falling edge so the far end samples it on the next rise
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      if (state == SJSR_SHF_IR) begin
        tdo_o    <= ir_sr_reg[0];
        tdo_oe_o <= 1'b1;
      end else if (state == SJSR_SHF_DR) begin
        tdo_o    <= dr_bit;
        tdo_oe_o <= 1'b1;
      end else begin
        tdo_oe_o <= 1'b0;
      end
    end
  end

  // Helper count of consecutive rises with mode select high
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tms_hi_cnt_reg <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_lvl) begin
        tms_hi_cnt_reg <= 3'h0;
      end else if (tms_hi_cnt_reg != `SJSR_TMS_RESET_RISES) begin
        tms_hi_cnt_reg <= tms_hi_cnt_reg + 3'h1;
      end
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  tms_reset_a: assert property (tms_hi_cnt_reg == `SJSR_TMS_RESET_RISES |-> state == SJSR_TLR)
    else $error("five high mode select rises did not reach test-logic-reset");

  ir_force_a: assert property (state == SJSR_TLR |=> instr_reg == `SJSR_IR_IDCODE)
    else $error("instruction not forced to IDCODE in test-logic-reset");

  ir_load_a: assert property ($changed(instr_reg) |->
      $past(state == SJSR_TLR) || $past(tck_rise && state == SJSR_UPD_IR))
    else $error("instruction changed outside update-IR");

  byp_capture_a: assert property (tck_rise && state == SJSR_CAP_DR && path == SJSR_PATH_BYP
      |=> !byp_reg)
    else $error("bypass bit not cleared on capture");

  byp_pass_a: assert property (tck_rise && state == SJSR_SHF_DR && path == SJSR_PATH_BYP
      |=> byp_reg == $past(tdi_lvl))
    else $error("bypass bit did not take data in");

  id_capture_a: assert property (tck_rise && state == SJSR_CAP_DR && path == SJSR_PATH_ID
      |=> id_sr_reg == ID_CODE && id_sr_reg[`SJSR_ID_FIX_BIT])
    else $error("identification code not captured");

  id_shift_a: assert property (tck_rise && state == SJSR_SHF_DR && path == SJSR_PATH_ID
      |=> id_sr_reg == {$past(tdi_lvl), $past(id_sr_reg[`SJSR_ID_W-1:1])})
    else $error("identification register shift wrong");

  bsr_capture_a: assert property (tck_rise && state == SJSR_CAP_DR && path == SJSR_PATH_BSR
      |=> bsr_sr_reg == $past(ring_cap) && !bsr_sr_reg[`SJSR_BSR_INT_IDX])
    else $error("boundary register did not sample the ring");

  bsr_shift_a: assert property (tck_rise && state == SJSR_SHF_DR && path == SJSR_PATH_BSR
      |=> bsr_sr_reg[`SJSR_BSR_W-1] == $past(tdi_lvl)
          && bsr_sr_reg[0] == $past(bsr_sr_reg[1]))
    else $error("boundary register shift wrong");

  reg_hold_a: assert property (!tck_rise |=> $stable(id_sr_reg) && $stable(bsr_sr_reg)
      && $stable(byp_reg))
    else $error("scan register moved without a test clock rise");

  bsr_paths_a: assert property (instr_reg == `SJSR_IR_SAMPLE || instr_reg == `SJSR_IR_EXTEST
      |-> path == SJSR_PATH_BSR)
    else $error("boundary register not selected");

  tdo_fall_a: assert property ($changed(tdo_o) || $changed(tdo_oe_o) |-> $past(tck_fall))
    else $error("data out changed away from a test clock fall");

  oe_shift_a: assert property (tck_fall |=>
      tdo_oe_o == $past(state == SJSR_SHF_IR || state == SJSR_SHF_DR))
    else $error("data out enable wrong at a test clock fall");

  id_shifted_c: cover property (tck_rise && state == SJSR_SHF_DR && path == SJSR_PATH_ID);
  byp_used_c: cover property (tck_rise && state == SJSR_SHF_DR && path == SJSR_PATH_BYP);
  ir_updated_c: cover property (tck_rise && state == SJSR_UPD_IR);
  bsr_captured_c: cover property (tck_rise && state == SJSR_CAP_DR && path == SJSR_PATH_BSR);

endmodule // sjsr_scan_regs

// ===== sim/sjsr_jtag_ctrl.sv
// Behavioural boundary-scan test controller driving the test port from outside.
// Assumes the caller starts scans from run-test/idle; tck period is 8 mclk_i.
`timescale 1ns/1ps
module sjsr_jtag_ctrl (
  input  wire logic mclk_i,
  input  wire logic tdo_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  initial begin
    tck_o = 1'b1;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // One test clock: fall with new tms/tdi, rise 4 mclk later; q is data out
  // of the previous fall, read late because the device answers 5 mclk after it
  task automatic cyc(input logic m, input logic d, output logic q);
    @(posedge mclk_i);
    q = tdo_i;
    tck_o <= 1'b0;
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge mclk_i);
    tck_o <= 1'b1;
    repeat (3) @(posedge mclk_i);
  endtask

  task automatic idle();
    logic t;
    cyc(1'b0, ~tdi_o, t);
  endtask

  // Serial load of instruction or data path; tdi toggles outside shift
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic t;
    int   j;
    cyc(1'b1, ~tdi_o, t);
    if (ir) cyc(1'b1, ~tdi_o, t);
    cyc(1'b0, ~tdi_o, t);
    cyc(1'b0, ~tdi_o, t);
    dout = '0;
    for (j = 0; j < n; j++) begin
      cyc(j == n - 1, din[j], t);
      if (j > 0) dout[j-1] = t;
    end
    cyc(1'b1, ~tdi_o, t);
    dout[n-1] = t;
    cyc(1'b0, ~tdi_o, t);
    // The last rise needs the device's synchroniser delay before results show
    repeat (4) @(posedge mclk_i);
  endtask
endmodule // sjsr_jtag_ctrl

// ===== sim/sjsr_scan_regs_bench.sv
// Self-checking bench for the scan register set, with a controller model.
// Assumes the design files and sjsr_defs.svh are compiled alongside.
`timescale 1ns/1ps
`include "sjsr_defs.svh"
`define SJSR_CHK(nm, ex, got) \
  begin \
    n_tests++; \
    if ((got) !== (ex)) begin \
      mismatches++; \
      $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end \
  end
module sjsr_scan_regs_bench;
  // Identification fields; the values are arbitrary
  localparam logic [3:0]  REV  = 4'h6;
  localparam logic [15:0] PART = 16'h3C1E;
  localparam logic [10:0] VEND = 11'h155;
  localparam int          NBIT = 111;

  logic                   mclk;
  logic                   reset;
  logic                   tck;
  logic                   tms;
  logic                   tdi;
  logic                   tdo;
  logic                   tdo_oe;
  logic                   tdo_line;
  logic                   drive_en;
  logic                   highz;
  logic [`SJSR_BSR_W-1:0] io_ring;
  logic [`SJSR_BSR_W-1:0] ring_drive;
  logic [`SJSR_BSR_W-1:0] ring_model;
  logic [2:0]             ir_model;
  logic [31:0]            seed;
  logic                   t;
  int                     mismatches;
  int                     n_tests;
  int                     cycles;
  int                     code;

  sjsr_scan_regs #(.ID_REVISION(REV), .ID_PART(PART), .ID_VENDOR(VEND)) u_dut (
    .mclk_i          (mclk),
    .reset_i         (reset),
    .tck_i           (tck),
    .tms_i           (tms),
    .tdi_i           (tdi),
    .io_ring_i       (io_ring),
    .tdo_o           (tdo),
    .tdo_oe_o        (tdo_oe),
    .ring_drive_o    (ring_drive),
    .ring_drive_en_o (drive_en),
    .q_highz_o       (highz)
  );

  // A released data out has no pull-up; show the inverse so a late read fails
  assign tdo_line = tdo_oe ? tdo : ~tdo;

  sjsr_jtag_ctrl u_ctrl (
    .mclk_i (mclk),
    .tdo_i  (tdo_line),
    .tck_o  (tck),
    .tms_o  (tms),
    .tdi_o  (tdi)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic draw(output logic [127:0] v);
    int i;
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = {v[95:0], seed};
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic ir_load(input logic [2:0] c);
    logic [127:0] din;
    logic [127:0] dout;
    din = {125'h0, c};
    u_ctrl.scan(1'b1, 3, din, dout);
    `SJSR_CHK("ir_capture", `SJSR_IR_CAPTURE, dout[2:0])
    ir_model = c;
    `SJSR_CHK("drive_en", (c == `SJSR_IR_EXTEST), drive_en)
    `SJSR_CHK("highz", (c == `SJSR_IR_SAMPLEZ), highz)
  endtask

  // Shifting past the register length also proves its exact width
  task automatic dr_check();
    logic [127:0] din;
    logic [127:0] dout;
    logic [127:0] cap;
    logic [127:0] rnd;
    logic [127:0] expv;
    int           w;
    draw(rnd);
    draw(din);
    io_ring <= rnd[`SJSR_BSR_W-1:0];
    case (ir_model)
      `SJSR_IR_EXTEST, `SJSR_IR_SAMPLEZ, `SJSR_IR_SAMPLE: begin
        cap = {21'h0, rnd[`SJSR_BSR_W-1:0]};
        cap[`SJSR_BSR_INT_IDX] = 1'b0;
        w = `SJSR_BSR_W;
      end
      `SJSR_IR_IDCODE: begin
        cap = {96'h0, REV, PART, VEND, 1'b1};
        w = `SJSR_ID_W;
      end
      default: begin
        cap = '0;
        w = 1;
      end
    endcase
    u_ctrl.scan(1'b0, NBIT, din, dout);
    expv = (cap | (din << w)) & ((128'h1 << NBIT) - 128'h1);
    `SJSR_CHK("dr_out", expv, dout)
    if (w == `SJSR_BSR_W) ring_model = din[NBIT-1:NBIT-`SJSR_BSR_W];
    `SJSR_CHK("ring_drive", ring_model, ring_drive)
    `SJSR_CHK("oe_idle", 1'b0, tdo_oe)
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    seed = 32'h22;
    reset = 1'b1;
    io_ring = '0;
    ring_model = '0;
    ir_model = `SJSR_IR_IDCODE;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (10) @(posedge mclk);
    u_ctrl.idle();
    dr_check();
    for (code = 0; code < 8; code++) begin
      ir_load(code[2:0]);
      dr_check();
    end
    // A data scan must leave the instruction alone
    dr_check();
    repeat (5) u_ctrl.cyc(1'b1, 1'b0, t);
    u_ctrl.idle();
    ir_model = `SJSR_IR_IDCODE;
    dr_check();
    print_verdict();
  end
endmodule // sjsr_scan_regs_bench
